/* shared/pcdp_pkg.sv */
package pcdp_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] PCDP_REG_CTRL       = 4'h3;  // Dataport control
    localparam logic [3:0] PCDP_REG_ADDR_HI    = 4'h4;  // Dataport address high
    localparam logic [3:0] PCDP_REG_ADDR_LO    = 4'h5;  // Dataport address low
    localparam logic [3:0] PCDP_REG_DATA       = 4'h6;  // Dataport data
    localparam logic [3:0] PCDP_REG_COMMAND    = 4'h7;  // Scan command register
    localparam logic [3:0] PCDP_REG_HDIV       = 4'h9;  // Horizontal resolution divider
    localparam logic [3:0] PCDP_REG_STATUS     = 4'ha;  // Block status

    // Control register fields
    localparam int PCDP_CTRL_PAUSE_BIT = 0;             // Read-only pause flag
    localparam int PCDP_CTRL_MODE_BIT  = 1;             // table_mode_select_bit
    localparam int PCDP_CTRL_OG_BIT    = 2;             // Offset (0) or gain (1)
    localparam int PCDP_CTRL_COLOR_LSB = 3;             // Colour select, two bits
    localparam int PCDP_ADDR_W         = 14;            // Dataport address width
    localparam int PCDP_RW_BIT         = PCDP_ADDR_W - 8; // Direction bit in high byte

    // Command values
    localparam logic [7:0] PCDP_CMD_IDLE  = 8'h00;
    localparam logic [7:0] PCDP_CMD_RESET = 8'h20;

    // Gain scale and gamma table geometry
    localparam int PCDP_GAIN_SHIFT = 14;                // Code / 16384
    localparam int PCDP_GAMMA_AW   = 12;
    localparam int PCDP_NUM_COLORS = 3;

    // Rate constants
    localparam int PCDP_CLK_MHZ      = 200;
    localparam int PCDP_STORE_MHZ    = 1;
    localparam int PCDP_STORE_CYCLES = PCDP_CLK_MHZ / PCDP_STORE_MHZ; // Longest rate, rounds down
    localparam int PCDP_MIN_DIV      = 6;

    typedef enum logic [1:0] {
        PCDP_SEL_OFFSET,
        PCDP_SEL_GAIN,
        PCDP_SEL_GAMMA
    } pcdp_sel_type;

    typedef struct packed {
        logic        valid;
        logic [1:0]  color;
        logic [15:0] data;
    } pcdp_pix_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pcdp_bus_type;
endpackage : pcdp_pkg

/* rtl/pcdp_core.sv */
module pcdp_core #(
    parameter int PIXELS   = 4096,                       // Coefficient entries per table
    parameter int MAX_HDIV = 12                          // Largest resolution divider
) (
    input  wire logic                  clk,              // 200 MHz clock
    input  wire logic                  nrst,             // Async reset, active low
    input  wire pcdp_pkg::pcdp_bus_type bus,             // Register port request
    output logic [7:0]                 rdata,            // Read data, cycle after read
    input  wire logic                  pause_in,         // Pause state from scan engine
    input  wire pcdp_pkg::pcdp_pix_type pix_in,          // Raw converter pixels
    output pcdp_pkg::pcdp_pix_type     pix_out,          // Gamma-corrected pixels
    output logic                       store_strobe,     // Buffer store pulse
    output logic                       refresh_en,       // DRAM refresh enable
    output logic                       scan_idle         // Command register at idle
);
    import pcdp_pkg::*;

    localparam int IDX_W = $clog2(PIXELS);

    initial begin
        if (PIXELS > (1 << PCDP_ADDR_W) || PIXELS < 2)
            $error("PIXELS out of range");
        if (MAX_HDIV < 1 || MAX_HDIV > 255)
            $error("MAX_HDIV out of range");
    end

    logic [7:0]              ctrl;
    logic [5:0]              addr_hi;
    logic [7:0]              addr_lo;
    logic [7:0]              command;
    logic [7:0]              hdiv;
    logic                    byte_phase;
    logic [7:0]              low_byte;
    logic                    tables_valid;
    logic [15:0]             offset_mem [PIXELS];
    logic [15:0]             gain_mem   [PIXELS];
    logic [7:0]              gamma_mem  [PCDP_NUM_COLORS][1 << PCDP_GAMMA_AW];

    wire  [PCDP_ADDR_W-1:0]  dp_addr = {addr_hi, addr_lo};
    wire  pcdp_sel_type      sel     = ctrl[PCDP_CTRL_MODE_BIT] ? PCDP_SEL_GAMMA :
                                       (ctrl[PCDP_CTRL_OG_BIT] ? PCDP_SEL_GAIN
                                                               : PCDP_SEL_OFFSET);
    wire  [1:0]              color   = ctrl[PCDP_CTRL_COLOR_LSB +: 2];
    wire  [PCDP_ADDR_W-1:0]  top_addr = (sel == PCDP_SEL_GAMMA)
        ? PCDP_ADDR_W'((1 << PCDP_GAMMA_AW) - 1) : PCDP_ADDR_W'(PIXELS - 1);
    wire                     data_wr = bus.wr && bus.addr == PCDP_REG_DATA;
    wire                     word_done = (sel != PCDP_SEL_GAMMA) ? byte_phase : 1'b1;
    logic [PCDP_ADDR_W-1:0]  next_addr;

    // Address step: wrap only from the exact top, illegal values run on
    always_comb begin
        if (dp_addr == top_addr)
            next_addr = '0;
        else
            next_addr = dp_addr + 1'b1;
    end

    // Control register; pause bit is never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            ctrl <= 8'h00;
        else if (bus.wr && bus.addr == PCDP_REG_CTRL)
            ctrl <= bus.wdata & ~(8'h01 << PCDP_CTRL_PAUSE_BIT);
    end

    // Dataport address with auto increment
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_hi <= 6'h00;
            addr_lo <= 8'h00;
        end else if (bus.wr && bus.addr == PCDP_REG_ADDR_HI) begin
            addr_hi <= bus.wdata[5:0];
        end else if (bus.wr && bus.addr == PCDP_REG_ADDR_LO) begin
            addr_lo <= bus.wdata;
        end else if (data_wr && word_done) begin
            {addr_hi, addr_lo} <= next_addr;
        end
    end

    // Direction bit just above the address field
    logic dp_read_dir;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            dp_read_dir <= 1'b0;
        else if (bus.wr && bus.addr == PCDP_REG_ADDR_HI)
            dp_read_dir <= bus.wdata[PCDP_RW_BIT];
    end

    // Byte pairing for 16-bit words; low byte first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_phase <= 1'b0;
            low_byte   <= 8'h00;
        end else if ((bus.wr && (bus.addr == PCDP_REG_ADDR_HI ||
                      bus.addr == PCDP_REG_ADDR_LO || bus.addr == PCDP_REG_CTRL)) ||
                     command == PCDP_CMD_RESET) begin
            byte_phase <= 1'b0;                          // Re-aim restarts pairing
        end else if (data_wr && sel != PCDP_SEL_GAMMA) begin
            byte_phase <= ~byte_phase;
            low_byte   <= bus.wdata;
        end
    end

    // Table memories; no reset so they map to RAM
    always_ff @(posedge clk) begin
        if (data_wr && !dp_read_dir) begin
            if (sel == PCDP_SEL_GAMMA && dp_addr < PCDP_ADDR_W'(1 << PCDP_GAMMA_AW)
                && color < 2'(PCDP_NUM_COLORS))
                gamma_mem[color][dp_addr[PCDP_GAMMA_AW-1:0]] <= bus.wdata;
            else if (sel == PCDP_SEL_GAIN && byte_phase && dp_addr < PCDP_ADDR_W'(PIXELS))
                gain_mem[dp_addr[IDX_W-1:0]] <= {bus.wdata, low_byte};
            else if (sel == PCDP_SEL_OFFSET && byte_phase && dp_addr < PCDP_ADDR_W'(PIXELS))
                offset_mem[dp_addr[IDX_W-1:0]] <= {bus.wdata, low_byte};
        end
    end

    // Command and divider registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            command <= PCDP_CMD_IDLE;
            hdiv    <= 8'h01;
        end else if (bus.wr && bus.addr == PCDP_REG_COMMAND) begin
            command <= bus.wdata;
        end else if (bus.wr && bus.addr == PCDP_REG_HDIV) begin
            hdiv <= (bus.wdata == 8'h00 || bus.wdata > 8'(MAX_HDIV)) ? 8'h01 : bus.wdata;
        end
    end

    // Chip reset stops refresh and marks tables stale until rewritten
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tables_valid <= 1'b0;
        end else if (command == PCDP_CMD_RESET) begin
            tables_valid <= 1'b0;
        end else if (data_wr && !dp_read_dir) begin
            tables_valid <= 1'b1;
        end
    end
    assign refresh_en = command != PCDP_CMD_RESET;
    assign scan_idle  = command == PCDP_CMD_IDLE;

    // Dataport read byte, chosen combinationally by the pairing phase
    logic [7:0] dp_rbyte;
    always_comb begin
        dp_rbyte = 8'h00;
        if (dp_addr < PCDP_ADDR_W'(PIXELS) && sel == PCDP_SEL_GAIN)
            dp_rbyte = byte_phase ? gain_mem[dp_addr[IDX_W-1:0]][15:8]
                                  : gain_mem[dp_addr[IDX_W-1:0]][7:0];
        else if (dp_addr < PCDP_ADDR_W'(PIXELS) && sel == PCDP_SEL_OFFSET)
            dp_rbyte = byte_phase ? offset_mem[dp_addr[IDX_W-1:0]][15:8]
                                  : offset_mem[dp_addr[IDX_W-1:0]][7:0];
        else if (sel == PCDP_SEL_GAMMA && dp_addr < PCDP_ADDR_W'(1 << PCDP_GAMMA_AW)
                 && color < 2'(PCDP_NUM_COLORS))
            dp_rbyte = gamma_mem[color][dp_addr[PCDP_GAMMA_AW-1:0]];
    end

    // Register read mux; one cycle latency, unmapped reads zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                PCDP_REG_CTRL:    rdata <= ctrl | (8'(pause_in) << PCDP_CTRL_PAUSE_BIT);
                PCDP_REG_ADDR_HI: rdata <= {1'b0, dp_read_dir, addr_hi};
                PCDP_REG_ADDR_LO: rdata <= addr_lo;
                PCDP_REG_DATA:    rdata <= dp_rbyte;
                PCDP_REG_COMMAND: rdata <= command;
                PCDP_REG_HDIV:    rdata <= hdiv;
                PCDP_REG_STATUS:  rdata <= {5'h00, refresh_en, tables_valid, byte_phase};
                default:          rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Resolution reduction: average hdiv consecutive raw pixels of any colour, colour taken from the last
    logic [7:0]  hcount;
    logic [23:0] hsum;
    logic        red_valid;
    logic [15:0] red_data;
    logic [1:0]  red_color;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hcount    <= 8'h00;
            hsum      <= 24'h000000;
            red_valid <= 1'b0;
            red_data  <= 16'h0000;
            red_color <= 2'h0;
        end else begin
            red_valid <= 1'b0;
            if (!scan_idle && pix_in.valid) begin
                if (hcount + 8'h01 >= hdiv) begin
                    red_valid <= 1'b1;
                    red_data  <= 16'((hsum + 24'(pix_in.data)) / 24'(hdiv));
                    red_color <= pix_in.color;
                    hcount    <= 8'h00;
                    hsum      <= 24'h000000;
                end else begin
                    hcount <= hcount + 8'h01;
                    hsum   <= hsum + 24'(pix_in.data);
                end
            end
        end
    end

    // Reduced-pixel index into coefficient tables
    logic [IDX_W-1:0] pix_idx;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            pix_idx <= '0;
        else if (scan_idle)
            pix_idx <= '0;
        else if (red_valid)
            pix_idx <= (pix_idx == IDX_W'(PIXELS - 1)) ? '0 : pix_idx + 1'b1;
    end

    // Offset then shading gain
    logic [16:0] offs;
    logic [32:0] prod;
    logic [15:0] corrected;
    always_comb begin
        offs = {1'b0, red_data} - {1'b0, offset_mem[pix_idx]};
        if (offs[16])
            offs = 17'h00000;                            // Clamp underflow
        prod = 33'(offs[15:0]) * 33'(gain_mem[pix_idx]);
        prod = prod >> PCDP_GAIN_SHIFT;
        if (gain_mem[pix_idx] == 16'h0000)
            corrected = 16'h0000;
        else if (prod > 33'h0ffff)
            corrected = 16'hffff;                        // Saturate scaled products above 16'hffff
        else
            corrected = prod[15:0];
    end

    // Store pacing: at most one pixel per microsecond into the buffer
    logic [7:0]  pace;
    logic        held_valid;
    logic [15:0] held_data;
    logic [1:0]  held_color;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pace       <= 8'h00;
            held_valid <= 1'b0;
            held_data  <= 16'h0000;
            held_color <= 2'h0;
        end else begin
            if (pace != 8'h00)
                pace <= pace - 8'h01;
            if (red_valid) begin
                held_valid <= 1'b1;
                held_data  <= corrected;
                held_color <= red_color;
            end else if (held_valid && pace == 8'h00) begin
                held_valid <= 1'b0;
                pace       <= 8'(PCDP_STORE_CYCLES - 1);
            end
        end
    end

    // Gamma lookup on the upper 12 bits, registered output
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pix_out      <= '0;
            store_strobe <= 1'b0;
        end else begin
            store_strobe  <= held_valid && pace == 8'h00 && !red_valid;
            pix_out.valid <= held_valid && pace == 8'h00 && !red_valid;
            pix_out.color <= held_color;
            if (held_color < 2'(PCDP_NUM_COLORS))
                pix_out.data <= {8'h00, gamma_mem[held_color]
                    [held_data[15 -: PCDP_GAMMA_AW]]};
            else
                pix_out.data <= 16'h0000;
        end
    end
endmodule : pcdp_core

/* verification/pcdp_core_sva.sv */
module pcdp_core_sva (
    input wire logic                   clk,          // Block clock
    input wire logic                   nrst,         // Async reset, active low
    input wire pcdp_pkg::pcdp_bus_type bus,          // Register request
    input wire logic [7:0]             rdata,        // Read data
    input wire logic                   pause_in,     // Pause level
    input wire pcdp_pkg::pcdp_pix_type pix_in,       // Raw pixels
    input wire pcdp_pkg::pcdp_pix_type pix_out,      // Corrected pixels
    input wire logic                   store_strobe, // Store pulse
    input wire logic                   refresh_en,   // Refresh enable
    input wire logic                   scan_idle     // Command idle
);
    import pcdp_pkg::*;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Cycles since the last store; saturates so the first store always passes
    logic [7:0] gap;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap <= 8'hff;
        end else if (store_strobe) begin
            gap <= 8'h01;
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end

    a_pause_shown: assert property (bus.rd && bus.addr == PCDP_REG_CTRL
        |=> rdata[0] == $past(pause_in)) else $error("pause flag not shown on read");
    a_hi_width: assert property (bus.rd && bus.addr == PCDP_REG_ADDR_HI
        |=> rdata[7] == 1'b0) else $error("address high byte too wide");
    a_store_pairs: assert property (store_strobe == pix_out.valid)
        else $error("store pulse apart from output pixel");
    a_store_rate: assert property (store_strobe |-> gap >= PCDP_STORE_CYCLES)
        else $error("stores closer than the storage rate");
    a_valid_gap: assert property (pix_out.valid |=> !pix_out.valid [*8])
        else $error("output pixels back to back");
    a_entry_byte: assert property (pix_out.valid |-> pix_out.data[15:8] == 8'h00)
        else $error("gamma output wider than a byte");
    a_reset_cmd: assert property (bus.wr && bus.addr == PCDP_REG_COMMAND
        && bus.wdata == PCDP_CMD_RESET |=> !refresh_en && !scan_idle)
        else $error("reset command left refresh running");
    a_idle_cmd: assert property (bus.wr && bus.addr == PCDP_REG_COMMAND
        && bus.wdata == PCDP_CMD_IDLE |=> scan_idle && refresh_en)
        else $error("idle command not shown");
    a_refresh_hold: assert property (!refresh_en
        && !(bus.wr && bus.addr == PCDP_REG_COMMAND) |=> !refresh_en)
        else $error("refresh restarted without a command");

    c_store: cover property (store_strobe);
    c_reset: cover property (bus.wr && bus.addr == PCDP_REG_COMMAND && !refresh_en);
    c_ctrl_read: cover property (bus.rd && bus.addr == PCDP_REG_CTRL && pause_in);
endmodule : pcdp_core_sva

bind pcdp_core pcdp_core_sva i_sva (
    .clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .pause_in(pause_in),
    .pix_in(pix_in), .pix_out(pix_out), .store_strobe(store_strobe),
    .refresh_en(refresh_en), .scan_idle(scan_idle)
);

/* verification/pcdp_host.sv */
module pcdp_host (
    input  wire logic             clk,   // Block clock
    input  wire logic [7:0]       rdata, // Device read data
    output pcdp_pkg::pcdp_bus_type bus   // Register requests
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcdp_pkg::*;

    initial bus = '0;

    // One-cycle write strobe; callers load tables only with the scan idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
endmodule : pcdp_host

/* verification/pixel_correction_dataport_test.sv */
module pixel_correction_dataport_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pcdp_pkg::*;

    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         pause_in = 1'b0;
    pcdp_bus_type bus;
    pcdp_pix_type pix_in = '0;
    pcdp_pix_type pix_out;
    logic [7:0]   rdata;
    logic         store_strobe;
    logic         refresh_en;
    logic         scan_idle;
    int           n_fail = 0;
    int           n_compared = 0;

    always #2.5 clk = ~clk;

    // Small table keeps loading short; wrap point is entry 15
    pcdp_core #(.PIXELS(16), .MAX_HDIV(12)) i_dut (
        .clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .pause_in(pause_in),
        .pix_in(pix_in), .pix_out(pix_out), .store_strobe(store_strobe),
        .refresh_en(refresh_en), .scan_idle(scan_idle)
    );
    pcdp_host i_host (.clk(clk), .rdata(rdata), .bus(bus));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic set_addr(input logic [13:0] a);
        i_host.wr(PCDP_REG_ADDR_HI, {2'b00, a[13:8]});
        i_host.wr(PCDP_REG_ADDR_LO, a[7:0]);
    endtask : set_addr

    // Coefficient words go low byte first
    task automatic put2(input logic [15:0] w);
        i_host.wr(PCDP_REG_DATA, w[7:0]);
        i_host.wr(PCDP_REG_DATA, w[15:8]);
    endtask : put2

    task automatic chk_addr(input logic [13:0] exp);
        logic [7:0] h;
        logic [7:0] l;
        i_host.rd(PCDP_REG_ADDR_HI, h);
        i_host.rd(PCDP_REG_ADDR_LO, l);
        check({2'b00, h[5:0], l}, {2'b00, exp});
    endtask : chk_addr

    // Pause bit ignores writes and follows the scan engine
    task automatic t_ctrl;
        logic [7:0] d;
        i_host.wr(PCDP_REG_CTRL, 8'h1f);
        i_host.rd(PCDP_REG_CTRL, d);
        check({8'h00, d & 8'h1f}, 16'h001e);
        pause_in <= 1'b1;
        i_host.wr(PCDP_REG_CTRL, 8'h00);
        i_host.rd(PCDP_REG_CTRL, d);
        check({8'h00, d & 8'h1f}, 16'h0001);
        pause_in <= 1'b0;
        $display("control test done");
    endtask : t_ctrl

    // Address stepping in gain and gamma modes and the wrap points
    task automatic t_addr;
        logic [7:0] d;
        i_host.wr(PCDP_REG_CTRL, 8'h04);
        set_addr(14'h0000);
        put2(16'h4000);
        chk_addr(14'h0001);
        i_host.wr(PCDP_REG_DATA, 8'h11);
        chk_addr(14'h0001);
        set_addr(14'h000f);
        put2(16'h4000);
        chk_addr(14'h0000);
        set_addr(14'h0020);
        put2(16'h4000);
        chk_addr(14'h0021);
        i_host.wr(PCDP_REG_CTRL, 8'h02);
        set_addr(14'h0ffe);
        put2(16'h0000);
        chk_addr(14'h0000);
        i_host.wr(PCDP_REG_ADDR_HI, 8'h40);
        i_host.rd(PCDP_REG_ADDR_HI, d);
        check({8'h00, d}, 16'h0040);
        i_host.wr(PCDP_REG_ADDR_HI, 8'h00);
        $display("address test done");
    endtask : t_addr

    task automatic t_cmd;
        i_host.wr(PCDP_REG_COMMAND, PCDP_CMD_RESET);
        #1 check({14'h0000, refresh_en, scan_idle}, 16'h0000);
        i_host.wr(PCDP_REG_COMMAND, PCDP_CMD_IDLE);
        #1 check({14'h0000, refresh_en, scan_idle}, 16'h0003);
        $display("command test done");
    endtask : t_cmd

    // Fill every coefficient, mark index idx in each colour, push hd raw pixels
    task automatic t_pix(input logic [15:0] off, input logic [15:0] gain,
                         input logic [15:0] px, input logic [1:0] c, input logic [11:0] idx,
                         input logic [7:0] hd);
        int i;
        i_host.wr(PCDP_REG_COMMAND, PCDP_CMD_IDLE);
        for (int m = 0; m < 2; m++) begin
            i_host.wr(PCDP_REG_CTRL, (m == 1) ? 8'h04 : 8'h00);
            set_addr(14'h0000);
            for (int e = 0; e < 16; e++) begin
                put2((m == 1) ? gain : off);
            end
        end
        for (int k = 0; k < 3; k++) begin
            i_host.wr(PCDP_REG_CTRL, {3'b000, 2'(k), 3'b010});
            set_addr({2'b00, idx});
            i_host.wr(PCDP_REG_DATA, {6'b001100, 2'(k)});
        end
        i_host.wr(PCDP_REG_CTRL, {3'b000, c, 3'b010});
        // Line of hd raw pixels keeps the line length at the divider
        i_host.wr(PCDP_REG_HDIV, hd);
        i_host.wr(PCDP_REG_COMMAND, 8'h01);
        // Pairs straddle px by 16 so only a true average lands on idx
        for (int j = 0; j < hd; j++) begin
            @(posedge clk);
            pix_in <= '{valid: 1'b1, color: c,
                        data: (hd == 8'h01) ? px : (j[0] ? px + 16'h0010 : px - 16'h0010)};
        end
        @(posedge clk);
        pix_in.valid <= 1'b0;
        for (i = 0; i < 400 && pix_out.valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i < 400) begin
            check(pix_out.data, {8'h00, 6'b001100, c});
            check({14'h0000, pix_out.color}, {14'h0000, c});
            check({15'h0000, store_strobe}, 16'h0001);
        end else begin
            n_fail++;
            test_done;
        end
        // Storage rate allows one pixel per this many cycles
        repeat (PCDP_STORE_CYCLES) @(posedge clk);
        $display("pixel test done");
    endtask : t_pix

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_ctrl;
        t_addr;
        t_cmd;
        t_pix(16'h0000, 16'h4000, 16'h1230, 2'd0, 12'h123, 8'h01);
        t_pix(16'h0100, 16'h8000, 16'h1330, 2'd1, 12'h246, 8'h02);
        t_pix(16'h0000, 16'h0000, 16'hffff, 2'd2, 12'h000, 8'h01);
        test_done;
    end
endmodule : pixel_correction_dataport_test
